// [inc/mdc_pkg.sv]
// Constants, codes and carrier types of the multi-function counter/delay macrocell.
package mdc_pkg;
    localparam int unsigned APB_AW = 12;
    localparam logic [1:0] BYTE_LANE_LSB = 2'h2;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_OPTIONS = 8'h56;
    localparam logic [7:0] IDX_ARRANGE = 8'h57;
    localparam logic [7:0] IDX_MODE_CLOCK = 8'h58;
    localparam logic [7:0] IDX_COUNTER_TWO_FUNC = 8'h59;
    localparam logic [7:0] IDX_COUNTER_TWO_INIT = 8'h5A;
    localparam logic [7:0] IDX_CNT23_OPT = 8'h5B;
    localparam logic [7:0] IDX_CELL3_ARR = 8'h5C;
    localparam logic [7:0] IDX_COUNTER_THREE_FUNC = 8'h5D;
    localparam logic [7:0] IDX_OWN_BASE = 8'h70;
    localparam logic [7:0] IDX_COUNT_DATA = 8'h70;
    localparam logic [7:0] IDX_TABLE = 8'h71;
    localparam logic [7:0] IDX_CLOCK_SEL = 8'h72;
    localparam logic [7:0] IDX_STATUS = 8'h73;
    localparam int unsigned NUM_SLOTS = 11;
    localparam logic [3:0] SLOT_OPTIONS = 4'h0;
    localparam logic [3:0] SLOT_ARRANGE = 4'h1;
    localparam logic [3:0] SLOT_MODE = 4'h2;
    localparam logic [3:0] SLOT_OWN_BASE = 4'h8;
    localparam logic [3:0] SLOT_DATA = 4'h8;
    localparam logic [3:0] SLOT_TABLE = 4'h9;
    localparam logic [3:0] SLOT_CLOCK = 4'hA;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Option bit positions and field positions.
    localparam int unsigned OPT_SETRST_BIT = 2;
    localparam int unsigned OPT_UPSYNC_BIT = 3;
    localparam int unsigned OPT_POL_BIT = 5;
    localparam int unsigned OPT_SYNC_BIT = 6;
    localparam int unsigned OPT_EDGE_DETECT_OPTION_BIT = 7;
    localparam int unsigned MODE_INIT_LSB = 4;
    localparam int unsigned STAT_COUNT_LSB = 8;
    // Arrangement codes.
    localparam logic [4:0] ARR_LUT = 5'h00;
    localparam logic [4:0] ARR_FLOP = 5'h10;
    localparam logic [4:0] ARR_CNT = 5'h01;
    localparam logic [4:0] ARR_CNT_IN2 = 5'h02;
    localparam logic [4:0] ARR_CNT_IN1 = 5'h06;
    localparam logic [4:0] ARR_CNT_IN0 = 5'h0A;
    localparam logic [4:0] ARR_CNT_D = 5'h12;
    localparam logic [4:0] ARR_CNT_SN = 5'h16;
    localparam logic [4:0] ARR_CNT_CLK = 5'h1A;
    localparam logic [4:0] ARR_LUT_CNT = 5'h03;
    localparam logic [4:0] ARR_FLOP_CNT = 5'h13;
    localparam int unsigned ARR_FLOP_BIT = 4;
    // Function groups: base code of each group, edge offset 0 both, 1 falling, 2 rising.
    localparam logic [3:0] FN_ONESHOT_BASE = 4'h3;
    localparam logic [3:0] FN_FREQ_BASE = 4'h6;
    localparam logic [3:0] FN_EDGE_BASE = 4'h9;
    localparam logic [3:0] FN_COUNT_BASE = 4'hC;
    localparam logic [3:0] FN_LEVEL_RESET = 4'hF;
    localparam logic [3:0] EDGE_OFS_FALL = 4'h1;
    localparam logic [3:0] EDGE_OFS_RISE = 4'h2;
    localparam logic [1:0] INIT_BYPASS = 2'h0;
    localparam logic [1:0] INIT_ZERO = 2'h1;
    // Clock source codes and divider terminal values (ratio minus one).
    localparam logic [3:0] CK_FAST = 4'h0;
    localparam logic [3:0] CK_FAST_D4 = 4'h1;
    localparam logic [3:0] CK_FAST_D8 = 4'h2;
    localparam logic [3:0] CK_FAST_D64 = 4'h3;
    localparam logic [3:0] CK_FAST_D512 = 4'h4;
    localparam logic [3:0] CK_SLOW = 4'h5;
    localparam logic [3:0] CK_SLOW_D8 = 4'h6;
    localparam logic [3:0] CK_SLOW_D12 = 4'h7;
    localparam logic [3:0] CK_SLOW_D24 = 4'h8;
    localparam logic [3:0] CK_SLOW_D64 = 4'h9;
    localparam logic [3:0] CK_SLOW_D512 = 4'hA;
    localparam logic [3:0] CK_SLOW_D4096 = 4'hB;
    localparam logic [3:0] CK_CHAIN = 4'hC;
    localparam logic [3:0] CK_EXT = 4'hD;
    localparam logic [11:0] DIV_1 = 12'h000;
    localparam logic [11:0] DIV_4 = 12'h003;
    localparam logic [11:0] DIV_8 = 12'h007;
    localparam logic [11:0] DIV_12 = 12'h00B;
    localparam logic [11:0] DIV_24 = 12'h017;
    localparam logic [11:0] DIV_64 = 12'h03F;
    localparam logic [11:0] DIV_512 = 12'h1FF;
    localparam logic [11:0] DIV_4096 = 12'hFFF;

    typedef enum logic [2:0] {MD_DELAY, MD_ONESHOT, MD_FREQ, MD_EDGE, MD_COUNT} mdc_mode_e;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } mdc_matrix_s;

    typedef struct packed {
        logic [NUM_SLOTS-1:0][7:0] regs;
        logic [31:0] prdata;
        logic [11:0] div;
        logic fast_q;
        logic slow_q;
        logic chain_q;
        logic ext_q;
        logic [1:0] sync_in;
        logic [1:0] sync_up;
        logic din_q;
        logic [7:0] count;
        logic busy;
        logic dly;
        logic init_done;
        logic ff_clk_q;
        logic ff_q;
    } mdc_state_s;
endpackage : mdc_pkg

// [hdl/mdc_cell.sv]
// Multi-function macrocell: lookup table or flip-flop plus 8-bit counter/delay behind an APB slave.
//
// Operation
// - Arrangement 00000 lone lookup table, 10000 lone flip-flop, 00001 lone counter/delay.
// - Codes 00010, 00110, 01010 feed delay output into table input 2, 1, 0.
// - Codes 10010, 10110, 11010 feed delay output into flop data, set/clear, clock.
// - Code 00011 feeds table output, 10011 flop output, into the delay input.
// - Function 0000, 0001, 0010: delay on both, falling or rising input edges.
// - Function 0011, 0100, 0101: one-shot on both, falling or rising edges.
// - Function 0110, 0111, 1000: frequency detector on both, falling or rising edges.
// - Function 1001, 1010, 1011: edge detector on both, falling or rising edges.
// - Function 1100-1110 counter reset by edges; 1111 holds reset while input high.
// - Initial value 00 bypasses, 01 starts output low, 10 or 11 high.
// - Clock codes 0000-0100: fast oscillator undivided or divided by 4, 8, 64, 512.
// - Clock codes 0101-1011: slow oscillator undivided or by 8, 12, 24, 64, 512, 4096.
// - Clock 1100 uses chain terminal count, 1101 the matrix clock input.
// - Polarity bit 0 passes the delay output, 1 inverts it.
// - In counter mode the sync bit adds two flip-flop stages on the input.
// - Edge-detect option turns delay completion into a one-tick pulse, delay codes only.
// - Set/reset bit 0 clears count, output high; 1 loads data, output low.
// - Count-up control has its own optional two-stage synchroniser.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mdc_cell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mdc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_oscillator,
    input wire logic slow_oscillator,
    input wire logic chain_terminal_count,
    input wire mdc_pkg::mdc_matrix_s matrix_in,
    input wire logic count_up_request,
    output logic delay_output,
    output logic cell_output
);
    mdc_pkg::mdc_state_s st_q;
    mdc_pkg::mdc_state_s st_d;
    logic [7:0] idx;
    logic [3:0] slot;
    logic mapped;
    logic [7:0] options;
    logic [4:0] arr;
    logic [3:0] func;
    logic [1:0] init_sel;
    logic [3:0] clk_sel;
    logic [7:0] data;
    logic [7:0] table_bits;
    logic [31:0] status;
    logic src_edge;
    logic tick;
    logic lut_in2;
    logic lut_in1;
    logic lut_in0;
    logic table_output;
    logic ff_d;
    logic ff_set_clear_low;
    logic ff_clk;
    logic delay_input_raw;
    logic delay_input;
    logic up;
    logic rise;
    logic fall;
    logic qual;
    logic reg_write;
    mdc_pkg::mdc_mode_e mode;
    logic [3:0] edge_ofs;

    function automatic logic [11:0] div_last(input logic [3:0] sel);
        logic [11:0] r;
        r = mdc_pkg::DIV_1;
        unique case (sel)
            mdc_pkg::CK_FAST_D4: r = mdc_pkg::DIV_4;
            mdc_pkg::CK_FAST_D8, mdc_pkg::CK_SLOW_D8: r = mdc_pkg::DIV_8;
            mdc_pkg::CK_SLOW_D12: r = mdc_pkg::DIV_12;
            mdc_pkg::CK_SLOW_D24: r = mdc_pkg::DIV_24;
            mdc_pkg::CK_FAST_D64, mdc_pkg::CK_SLOW_D64: r = mdc_pkg::DIV_64;
            mdc_pkg::CK_FAST_D512, mdc_pkg::CK_SLOW_D512: r = mdc_pkg::DIV_512;
            mdc_pkg::CK_SLOW_D4096: r = mdc_pkg::DIV_4096;
            default: r = mdc_pkg::DIV_1;
        endcase
        return r;
    endfunction : div_last

    assign idx = paddr[9:2];
    assign mapped = (paddr[mdc_pkg::APB_AW-1:10] == 2'h0) && (paddr[1:0] == 2'h0)
        && (((idx >= mdc_pkg::IDX_OPTIONS) && (idx <= mdc_pkg::IDX_COUNTER_THREE_FUNC))
        || ((idx >= mdc_pkg::IDX_OWN_BASE) && (idx <= mdc_pkg::IDX_STATUS)));
    assign slot = (idx >= mdc_pkg::IDX_OWN_BASE) ? 4'(idx - mdc_pkg::IDX_OWN_BASE) + mdc_pkg::SLOT_OWN_BASE
        : 4'(idx - mdc_pkg::IDX_OPTIONS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign reg_write = psel && penable && pwrite && mapped && pstrb[0] && (idx != mdc_pkg::IDX_STATUS);
    assign prdata = st_q.prdata;

    assign options = st_q.regs[mdc_pkg::SLOT_OPTIONS];
    assign arr = st_q.regs[mdc_pkg::SLOT_ARRANGE][4:0];
    assign func = st_q.regs[mdc_pkg::SLOT_MODE][3:0];
    assign init_sel = st_q.regs[mdc_pkg::SLOT_MODE][mdc_pkg::MODE_INIT_LSB +: 2];
    assign clk_sel = st_q.regs[mdc_pkg::SLOT_CLOCK][3:0];
    assign data = st_q.regs[mdc_pkg::SLOT_DATA];
    assign table_bits = st_q.regs[mdc_pkg::SLOT_TABLE];
    assign status = {16'h0000, st_q.count, 5'h00, st_q.busy, cell_output, delay_output};

    always_comb begin
        unique case (clk_sel)
            mdc_pkg::CK_FAST, mdc_pkg::CK_FAST_D4, mdc_pkg::CK_FAST_D8, mdc_pkg::CK_FAST_D64,
            mdc_pkg::CK_FAST_D512: src_edge = fast_oscillator && !st_q.fast_q;
            mdc_pkg::CK_CHAIN: src_edge = chain_terminal_count && !st_q.chain_q;
            mdc_pkg::CK_EXT: src_edge = matrix_in.b && !st_q.ext_q;
            default: src_edge = (clk_sel <= mdc_pkg::CK_SLOW_D4096) && slow_oscillator && !st_q.slow_q;
        endcase
    end
    assign tick = src_edge && (st_q.div == div_last(clk_sel));

    assign delay_output = st_q.dly ^ options[mdc_pkg::OPT_POL_BIT];

    // Delay output into a table input.
    assign lut_in2 = (arr == mdc_pkg::ARR_CNT_IN2) ? delay_output : matrix_in.a;
    assign lut_in1 = (arr == mdc_pkg::ARR_CNT_IN1) ? delay_output : matrix_in.b;
    assign lut_in0 = (arr == mdc_pkg::ARR_CNT_IN0) ? delay_output : matrix_in.c;
    assign table_output = table_bits[{lut_in2, lut_in1, lut_in0}];
    // Delay output into a flop pin.
    assign ff_d = (arr == mdc_pkg::ARR_CNT_D) ? delay_output : matrix_in.a;
    assign ff_set_clear_low = (arr == mdc_pkg::ARR_CNT_SN) ? delay_output : matrix_in.b;
    assign ff_clk = (arr == mdc_pkg::ARR_CNT_CLK) ? delay_output : matrix_in.c;
    // Cell output is the flop when the arrangement's top bit is set.
    assign cell_output = arr[mdc_pkg::ARR_FLOP_BIT] ? st_q.ff_q : table_output;

    always_comb begin
        unique case (arr)
            mdc_pkg::ARR_CNT, mdc_pkg::ARR_CNT_IN2, mdc_pkg::ARR_CNT_D: delay_input_raw = matrix_in.a;
            mdc_pkg::ARR_CNT_IN1, mdc_pkg::ARR_CNT_SN: delay_input_raw = matrix_in.b;
            mdc_pkg::ARR_CNT_IN0, mdc_pkg::ARR_CNT_CLK: delay_input_raw = matrix_in.c;
            mdc_pkg::ARR_LUT_CNT: delay_input_raw = table_output;
            mdc_pkg::ARR_FLOP_CNT: delay_input_raw = st_q.ff_q;
            default: delay_input_raw = 1'b0;
        endcase
    end

    always_comb begin
        if (func < mdc_pkg::FN_ONESHOT_BASE) begin
            mode = mdc_pkg::MD_DELAY;
            edge_ofs = func;
        end else if (func < mdc_pkg::FN_FREQ_BASE) begin
            mode = mdc_pkg::MD_ONESHOT;
            edge_ofs = func - mdc_pkg::FN_ONESHOT_BASE;
        end else if (func < mdc_pkg::FN_EDGE_BASE) begin
            mode = mdc_pkg::MD_FREQ;
            edge_ofs = func - mdc_pkg::FN_FREQ_BASE;
        end else if (func < mdc_pkg::FN_COUNT_BASE) begin
            mode = mdc_pkg::MD_EDGE;
            edge_ofs = func - mdc_pkg::FN_EDGE_BASE;
        end else begin
            mode = mdc_pkg::MD_COUNT;
            edge_ofs = func - mdc_pkg::FN_COUNT_BASE;
        end
    end

    // Optional two-stage synchronisers; only the second stage is read.
    assign delay_input = ((mode == mdc_pkg::MD_COUNT) && options[mdc_pkg::OPT_SYNC_BIT]) ? st_q.sync_in[1] : delay_input_raw;
    assign up = options[mdc_pkg::OPT_UPSYNC_BIT] ? st_q.sync_up[1] : count_up_request;
    assign rise = delay_input && !st_q.din_q;
    assign fall = !delay_input && st_q.din_q;
    assign qual = (edge_ofs == mdc_pkg::EDGE_OFS_RISE) ? rise : (edge_ofs == mdc_pkg::EDGE_OFS_FALL) ? fall
        : (rise || fall) && (func != mdc_pkg::FN_LEVEL_RESET);

    always_comb begin
        st_d = st_q;
        // Read data is captured in the setup phase so the access phase needs no wait state.
        if (psel && !penable) begin
            st_d.prdata = 32'h0000_0000;
            if (mapped && (idx == mdc_pkg::IDX_STATUS)) begin
                st_d.prdata = status;
            end else if (mapped) begin
                st_d.prdata = {24'h000000, st_q.regs[slot]};
            end
        end
        if (reg_write) begin
            st_d.regs[slot] = pwdata[7:0];
        end
        st_d.fast_q = fast_oscillator;
        st_d.slow_q = slow_oscillator;
        st_d.chain_q = chain_terminal_count;
        st_d.ext_q = matrix_in.b;
        // Flop with active-low clear, clocked on its selected clock rising.
        st_d.ff_clk_q = ff_clk;
        if (!ff_set_clear_low) begin
            st_d.ff_q = 1'b0;
        end else if (ff_clk && !st_q.ff_clk_q) begin
            st_d.ff_q = ff_d;
        end
        if (src_edge) begin
            st_d.div = tick ? mdc_pkg::DIV_1 : st_q.div + 12'h001;
        end
        if (!st_q.init_done) begin
            st_d.init_done = 1'b1;
            if (init_sel != mdc_pkg::INIT_BYPASS) begin
                st_d.dly = (init_sel != mdc_pkg::INIT_ZERO);
            end
        end else if (tick) begin
            // Synchroniser stages step on the cell clock.
            st_d.sync_in = {st_q.sync_in[0], delay_input_raw};
            st_d.sync_up = {st_q.sync_up[0], count_up_request};
            st_d.din_q = delay_input;
            unique case (mode)
                mdc_pkg::MD_DELAY: begin
                    // Delay qualifying edges; others pass at once only while idle with edge-detect off.
                    if (options[mdc_pkg::OPT_EDGE_DETECT_OPTION_BIT]) begin
                        st_d.dly = 1'b0;
                    end
                    if (qual) begin
                        st_d.count = data;
                        st_d.busy = 1'b1;
                    end else if (st_q.busy && (st_q.count == 8'h00)) begin
                        st_d.busy = 1'b0;
                        st_d.dly = options[mdc_pkg::OPT_EDGE_DETECT_OPTION_BIT] ? 1'b1 : delay_input;
                    end else if (st_q.busy) begin
                        st_d.count = st_q.count - 8'h01;
                    end else if ((rise || fall) && !options[mdc_pkg::OPT_EDGE_DETECT_OPTION_BIT]) begin
                        st_d.dly = delay_input;
                    end
                end
                mdc_pkg::MD_ONESHOT: begin
                    // Pulse of data+1 ticks, retriggers ignored while running.
                    if (qual && !st_q.busy) begin
                        st_d.dly = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.count = data;
                    end else if (st_q.busy && (st_q.count == 8'h00)) begin
                        st_d.dly = 1'b0;
                        st_d.busy = 1'b0;
                    end else if (st_q.busy) begin
                        st_d.count = st_q.count - 8'h01;
                    end
                end
                mdc_pkg::MD_FREQ: begin
                    // High while qualifying edges come within data+1 ticks.
                    if (qual) begin
                        st_d.dly = st_q.busy;
                        st_d.busy = 1'b1;
                        st_d.count = data;
                    end else if (st_q.busy && (st_q.count == 8'h00)) begin
                        st_d.dly = 1'b0;
                        st_d.busy = 1'b0;
                    end else if (st_q.busy) begin
                        st_d.count = st_q.count - 8'h01;
                    end
                end
                mdc_pkg::MD_EDGE: begin
                    st_d.dly = qual;
                end
                mdc_pkg::MD_COUNT: begin
                    // Counter reset by edge or by high level.
                    if (qual || ((func == mdc_pkg::FN_LEVEL_RESET) && delay_input)) begin
                        st_d.count = options[mdc_pkg::OPT_SETRST_BIT] ? data : 8'h00;
                        st_d.dly = !options[mdc_pkg::OPT_SETRST_BIT];
                    end else if (up) begin
                        st_d.dly = (st_q.count == data);
                        st_d.count = (st_q.count == data) ? 8'h00 : st_q.count + 8'h01;
                    end else begin
                        st_d.dly = (st_q.count == 8'h00);
                        st_d.count = (st_q.count == 8'h00) ? data : st_q.count - 8'h01;
                    end
                end
            endcase
        end
        // Reapply initial value.
        // Reset clears the field, so the value takes effect on the cycle after each write of it.
        if (reg_write && (slot == mdc_pkg::SLOT_MODE)) begin
            st_d.init_done = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_lut_alone: assert property ((arr == mdc_pkg::ARR_LUT) |->
        cell_output == table_bits[{matrix_in.a, matrix_in.b, matrix_in.c}])
        else $error("Lone table output wrong.");
    a_route_in2: assert property ((arr == mdc_pkg::ARR_CNT_IN2) |->
        cell_output == table_bits[{delay_output, matrix_in.b, matrix_in.c}])
        else $error("Delay output not on table input 2.");
    a_flop_clear: assert property ((arr == mdc_pkg::ARR_CNT_SN) && !delay_output |=> !st_q.ff_q)
        else $error("Delay output did not clear the flop.");
    a_feed_table: assert property ((arr == mdc_pkg::ARR_LUT_CNT) |-> delay_input_raw == table_output)
        else $error("Table output not fed to delay input.");
    a_oneshot_start: assert property (st_q.init_done && tick && rise && !st_q.busy
        && (func == mdc_pkg::FN_ONESHOT_BASE + mdc_pkg::EDGE_OFS_RISE)
        |=> st_q.dly && st_q.busy && (st_q.count == data))
        else $error("One-shot did not start on rising edge.");
    a_edge_pulse: assert property (st_q.init_done && tick && rise
        && (func == mdc_pkg::FN_EDGE_BASE + mdc_pkg::EDGE_OFS_RISE) |=> st_q.dly)
        else $error("Rising edge detector gave no pulse.");
    a_count_clear: assert property (st_q.init_done && tick && (mode == mdc_pkg::MD_COUNT)
        && qual && !options[mdc_pkg::OPT_SETRST_BIT] |=> (st_q.count == 8'h00) && st_q.dly)
        else $error("Counter reset did not clear count with output high.");
    a_pol_invert: assert property ($changed(options[mdc_pkg::OPT_POL_BIT]) && $stable(st_q.dly)
        |-> $changed(delay_output))
        else $error("Polarity change did not flip the output.");
    a_sync_delay: assert property (st_q.init_done && tick |=>
        st_q.sync_in == {$past(st_q.sync_in[0]), $past(delay_input_raw)})
        else $error("Synchroniser stages did not follow the cell clock.");
    a_sync_hold: assert property (!tick |=> $stable(st_q.sync_in))
        else $error("Synchroniser stepped without a cell clock tick.");
    a_init_zero: assert property (!st_q.init_done && (init_sel == mdc_pkg::INIT_ZERO) |=> !st_q.dly)
        else $error("Initial value zero not applied.");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && pready)
        else $error("Unmapped access not flagged.");
endmodule : mdc_cell
`default_nettype wire

// [tb/mdc_matrix_model.sv]
// Behavioural model of the interconnect matrix that feeds the macrocell.
`timescale 1ns/1ps
`default_nettype none
module mdc_matrix_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire mdc_pkg::mdc_matrix_s want,
    output logic fast_oscillator,
    output logic slow_oscillator,
    output logic chain_terminal_count,
    output mdc_pkg::mdc_matrix_s matrix_in
);
    logic [7:0] div_q;
    // free-running sources.
    // The sources run free except while presetn holds them at zero; the slow one is kept far slower.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
            matrix_in <= 3'h0;
        end else begin
            div_q <= div_q + 8'h01;
            matrix_in <= want;
        end
    end
    assign fast_oscillator = div_q[1];
    assign slow_oscillator = div_q[6];
    assign chain_terminal_count = div_q[7];
endmodule : mdc_matrix_model
`default_nettype wire

// [tb/multifunction_delay_counter_cell_tb.sv]
// Self-checking testbench of the counter/delay macrocell.
`timescale 1ns/1ps
`default_nettype none
module multifunction_delay_counter_cell_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, fast_o, slow_o, chain_o, delay_output, cell_output;
    mdc_pkg::mdc_matrix_s want = 3'h0;
    mdc_pkg::mdc_matrix_s mx;
    int n_mismatch = 0;
    int compares = 0;
    logic [7:0] rd;
    logic er;
    int ticks;

    always #2 pclk = ~pclk;

    mdc_matrix_model mdc_matrix_model_i (.pclk(pclk), .presetn(presetn), .want(want),
        .fast_oscillator(fast_o), .slow_oscillator(slow_o), .chain_terminal_count(chain_o), .matrix_in(mx));
    mdc_cell mdc_cell_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_oscillator(fast_o), .slow_oscillator(slow_o), .chain_terminal_count(chain_o),
        .matrix_in(mx), .count_up_request(1'b0), .delay_output(delay_output), .cell_output(cell_output));

    task automatic finish_test;
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Caller is just past a rising edge; the request holds until pready is seen.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle keeps two calls from driving psel twice in one time step.
        @(posedge pclk);
        if (n >= 50) begin
            n_mismatch++;
            finish_test();
        end
    endtask : apb

    // Counts fast-source rising edges until the delay output reaches a level.
    task automatic wait_out(input logic lvl);
        logic prev;
        prev = fast_o;
        ticks = 0;
        for (int i = 0; i < 400 && delay_output !== lvl; i++) begin
            @(posedge pclk);
            if (fast_o === 1'b1 && prev === 1'b0) ticks++;
            prev = fast_o;
        end
        if (delay_output !== lvl) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_out

    task automatic regs_test;
        for (int i = 8'h56; i <= 8'h5D; i++) begin
            apb(1'b0, 8'(i), 8'h00);
            check({24'h0, rd}, {24'h0, mdc_pkg::REG_RESET});
            apb(1'b1, 8'(i), 8'(8'hA5 ^ i));
            apb(1'b0, 8'(i), 8'h00);
            check({24'h0, rd}, {24'h0, 8'(8'hA5 ^ i)});
            apb(1'b1, 8'(i), 8'h00);
        end
        apb(1'b0, 8'h40, 8'h00);
        check({23'h0, er, rd}, {23'h0, 1'b1, 8'h00});
    endtask : regs_test

    task automatic table_test;
        apb(1'b1, mdc_pkg::IDX_TABLE, 8'hB4);
        apb(1'b1, mdc_pkg::IDX_ARRANGE, {3'h0, mdc_pkg::ARR_LUT});
        for (int i = 0; i < 8; i++) begin
            want <= 3'(i);
            repeat (3) @(posedge pclk);
            check({31'h0, cell_output}, {31'h0, 1'(8'hB4 >> i)});
        end
        want <= 3'h0;
    endtask : table_test

    task automatic polarity_test;
        apb(1'b1, mdc_pkg::IDX_OPTIONS, 8'h20);
        repeat (2) @(posedge pclk);
        check({31'h0, delay_output}, 32'h1);
        apb(1'b1, mdc_pkg::IDX_OPTIONS, 8'h00);
        repeat (2) @(posedge pclk);
        check({31'h0, delay_output}, 32'h0);
    endtask : polarity_test

    // A second reset in mid-run clears what the register sweep left behind.
    task automatic reset_test;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({30'h0, delay_output, cell_output}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, mdc_pkg::IDX_MODE_CLOCK, 8'h00);
        check({24'h0, rd}, {24'h0, mdc_pkg::REG_RESET});
    endtask : reset_test

    task automatic init_test;
        apb(1'b1, mdc_pkg::IDX_MODE_CLOCK, 8'h20);
        repeat (2) @(posedge pclk);
        check({31'h0, delay_output}, 32'h1);
        apb(1'b1, mdc_pkg::IDX_MODE_CLOCK, 8'h10);
        repeat (2) @(posedge pclk);
        check({31'h0, delay_output}, 32'h0);
    endtask : init_test

    // One rising then one falling input edge; ticks are counted until each output change.
    task automatic edge_run(input logic [7:0] fn, input logic [7:0] cnt, input int n_up, input int n_down);
        apb(1'b1, mdc_pkg::IDX_COUNT_DATA, cnt);
        apb(1'b1, mdc_pkg::IDX_MODE_CLOCK, fn);
        repeat (20) @(posedge pclk);
        // Start just after a tick, so that the counts are exact; the first includes the qualifying tick.
        for (int i = 0; i < 8 && fast_o !== 1'b0; i++) @(posedge pclk);
        for (int i = 0; i < 8 && fast_o !== 1'b1; i++) @(posedge pclk);
        want <= 3'h4;
        wait_out(1'b1);
        check(ticks, n_up);
        want <= 3'h0;
        wait_out(1'b0);
        check(ticks, n_down);
    endtask : edge_run

    task automatic function_test;
        apb(1'b1, mdc_pkg::IDX_ARRANGE, {3'h0, mdc_pkg::ARR_CNT});
        apb(1'b1, mdc_pkg::IDX_CLOCK_SEL, {4'h0, mdc_pkg::CK_FAST});
        // Delay: output follows after data+1 ticks; the falling edge passes in the next tick.
        edge_run(8'h02, 8'h03, 5, 1);
        // One-shot: high for data+1 ticks.
        edge_run(8'h05, 8'h03, 1, 4);
        edge_run(8'h0B, 8'h03, 1, 1);
        // Counter reset: count zero and output high, then the zero-count pulse, then low.
        edge_run(8'h0E, 8'hFF, 1, 2);
    endtask : function_test

    initial begin
        repeat (10) @(posedge pclk);
        check({30'h0, delay_output, cell_output}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_test();
        reset_test();
        table_test();
        polarity_test();
        init_test();
        function_test();
        finish_test();
    end
endmodule : multifunction_delay_counter_cell_tb
`default_nettype wire
